// ==== hw/pism_summary_mask.sv ====
// interrupt summary byte, mask register and interrupt output
`timescale 1ns/10ps
`default_nettype none
`include "pism_params.svh"

module pism_summary_mask
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register access by command code
    input wire logic [7:0] i_cmd,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // global enable from the general mask register
    input wire logic i_global_irq_enable,
    // supply flags
    input wire logic i_thermal_shutdown_flag,
    input wire logic i_digital_supply_low_flag,
    input wire logic i_power_supply_low_flag,
    // per-port flags, already cleared by their event registers
    input wire logic [3:0] i_port_start_timeout_flag,
    input wire logic [3:0] i_port_overload_cut_flag,
    input wire logic [3:0] i_port_current_limit_flag,
    input wire logic [3:0] i_port_class_cycle_flag,
    input wire logic [3:0] i_port_detect_cycle_flag,
    input wire logic [3:0] i_port_disconnect_flag,
    input wire logic [3:0] i_port_power_good_change_flag,
    input wire logic [3:0] i_port_power_enable_change_flag,
    // outputs
    output logic [7:0] o_event_summary_status,
    output logic o_supply_uv_shutoff_en,
    output logic o_int_n
);

    // ==========================================================
    // summary byte
    wire pism_pkg::pism_byte_t summary;
    pism_pkg::pism_byte_t mask_reg;
    pism_pkg::pism_byte_t mask_next;
    pism_pkg::pism_byte_t rdata_reg;
    pism_pkg::pism_byte_t rdata_next;
    logic mask_written_reg;
    logic int_n_reg;
    logic int_n_next;
    wire logic mask_wr;
    wire logic sum_sel;
    wire logic mask_sel;

    // combinational OR of live flags, independent of mask
    assign summary[`PISM_BIT_SUPPLY] = i_thermal_shutdown_flag
        | i_digital_supply_low_flag | i_power_supply_low_flag;
    assign summary[`PISM_BIT_START] = |i_port_start_timeout_flag;
    assign summary[`PISM_BIT_OVERCURRENT] = |{i_port_overload_cut_flag,
        i_port_current_limit_flag};
    assign summary[`PISM_BIT_CLASS] = |i_port_class_cycle_flag;
    assign summary[`PISM_BIT_DETECT] = |i_port_detect_cycle_flag;
    assign summary[`PISM_BIT_DISCONNECT] = |i_port_disconnect_flag;
    assign summary[`PISM_BIT_PGOOD] =
        |i_port_power_good_change_flag;
    assign summary[`PISM_BIT_PENABLE] =
        |i_port_power_enable_change_flag;
    // cleared flags upstream drop the summary directly
    assign o_event_summary_status = summary;

    // ==========================================================
    // register access
    assign sum_sel = (i_cmd == `PISM_CMD_SUMMARY);
    assign mask_sel = (i_cmd == `PISM_CMD_MASK);
    assign mask_wr = i_wr & mask_sel; // summary writes are ignored
    assign mask_next = mask_wr ? i_wdata : mask_reg;
    assign rdata_next = !i_rd ? rdata_reg :
        sum_sel ? summary : mask_sel ? mask_reg : 8'h00;

    // mask per summary bit, same position
    assign int_n_next = ~(i_global_irq_enable
        & |(summary & mask_reg));
    assign o_supply_uv_shutoff_en = mask_reg[`PISM_BIT_SUPPLY];

    // mask, read data and interrupt output registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mask_reg <= `PISM_MASK_RESET;
            rdata_reg <= 8'h00;
            int_n_reg <= 1'b1;
        end
        else
        begin
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            int_n_reg <= int_n_next;
        end
    end
    assign o_int_n = int_n_reg;
    assign o_rdata = rdata_reg;

    // remembers the first mask write, so the reset value can be checked
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            mask_written_reg <= 1'b0;
        else
            mask_written_reg <= mask_written_reg | mask_wr;
    end

    // ==========================================================
    // checks
    property p_summary_supply;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_event_summary_status[7] == (i_thermal_shutdown_flag
            | i_digital_supply_low_flag | i_power_supply_low_flag);
    endproperty
    a_summary_supply: assert property (p_summary_supply)
        else $error("supply summary wrong");

    property p_summary_over;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_event_summary_status[5] == |{i_port_overload_cut_flag,
            i_port_current_limit_flag};
    endproperty
    a_summary_over: assert property (p_summary_over)
        else $error("overcurrent summary wrong");

    property p_mask_write;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_cmd == `PISM_CMD_MASK) |=> mask_reg == $past(i_wdata);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write lost");

    property p_mask_readback;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_cmd == `PISM_CMD_MASK) |=> o_rdata == $past(mask_reg);
    endproperty
    a_mask_readback: assert property (p_mask_readback)
        else $error("mask readback wrong");

    property p_status_read;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_cmd == `PISM_CMD_SUMMARY) |=> o_rdata == $past(summary);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read wrong");

    property p_status_ro;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_cmd == `PISM_CMD_SUMMARY) |=> $stable(mask_reg);
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("status write changed mask");

    sequence s_cause;
        i_global_irq_enable && (summary & mask_reg) != 8'h00;
    endsequence
    property p_int_assert;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_cause |=> !o_int_n;
    endproperty
    a_int_assert: assert property (p_int_assert)
        else $error("interrupt not asserted");

    property p_int_release;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!i_global_irq_enable || (summary & mask_reg) == 8'h00) |=> o_int_n;
    endproperty
    a_int_release: assert property (p_int_release)
        else $error("interrupt not released");

    property p_supply_shutoff;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_cmd == `PISM_CMD_MASK) |=>
            o_supply_uv_shutoff_en == $past(i_wdata[`PISM_BIT_SUPPLY]);
    endproperty
    a_supply_shutoff: assert property (p_supply_shutoff)
        else $error("shutoff enable wrong");

    // until the host writes it, the mask keeps its reset pattern
    property p_mask_reset;
        @(posedge i_clk) disable iff (!i_rst_n)
        !mask_written_reg |-> mask_reg == `PISM_MASK_RESET;
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("mask lost its reset value");

    // an active flag with its mask bit clear must not pull the line
    property p_mask_block;
        @(posedge i_clk) disable iff (!i_rst_n)
        (summary != 8'h00 && (summary & mask_reg) == 8'h00) |=> o_int_n;
    endproperty
    a_mask_block: assert property (p_mask_block)
        else $error("masked flag raised interrupt");

    // a low interrupt line always has an enabled, unmasked cause behind it
    property p_int_cause;
        @(posedge i_clk) disable iff (!i_rst_n)
        !o_int_n |-> $past(i_global_irq_enable)
            && ($past(summary) & $past(mask_reg)) != 8'h00;
    endproperty
    a_int_cause: assert property (p_int_cause)
        else $error("interrupt without a cause");

    // codes other than the two registers read back as zero
    property p_other_read;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_cmd != `PISM_CMD_SUMMARY && i_cmd != `PISM_CMD_MASK)
            |=> o_rdata == 8'h00;
    endproperty
    a_other_read: assert property (p_other_read)
        else $error("unknown code read not zero");

endmodule
`default_nettype wire

// ==== hw/pism_params.svh ====
// constants for the interrupt summary and mask block
`ifndef PISM_PARAMS_SVH
`define PISM_PARAMS_SVH
`define PISM_CMD_SUMMARY 8'h00
`define PISM_CMD_MASK 8'h01
`define PISM_MASK_RESET 8'h80
`define PISM_BIT_SUPPLY 7
`define PISM_BIT_START 6
`define PISM_BIT_OVERCURRENT 5
`define PISM_BIT_CLASS 4
`define PISM_BIT_DETECT 3
`define PISM_BIT_DISCONNECT 2
`define PISM_BIT_PGOOD 1
`define PISM_BIT_PENABLE 0
`endif

// ==== hw/pism_pkg.sv ====
// types for the interrupt summary and mask block
package pism_pkg;
    typedef logic [7:0] pism_byte_t;
endpackage

// ==== verification/pism_event_model.sv ====
// event flag holder standing in for the per-port event registers
`timescale 1ns/10ps
`default_nettype none
module pism_event_model
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // set requests and a clear strobe
    input wire logic [34:0] i_set,
    input wire logic i_clr,
    // held flags
    output logic [34:0] o_flags
);
    // flags hold until cleared; supply flag comes up set; an event that
    // lands in the clearing cycle survives the clear
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_flags <= 35'h100000000;
        else
            o_flags <= (i_clr ? 35'h0 : o_flags) | i_set;
    end
endmodule
`default_nettype wire

// ==== verification/test_pism_summary_mask.sv ====
// self-checking bench for the interrupt summary and mask block
`timescale 1ns/10ps
`default_nettype none
`include "pism_params.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module test_pism_summary_mask;
    // ==========================================
    // signals and instances
    logic clk, rst_n, wr, rd, gen, clr;
    logic [7:0] cmd, wdata, rdata, summ;
    logic [34:0] set, flg;
    logic shut, int_n;
    logic [7:0] exp_bit;
    int n_errors = 0;
    int n_compared = 0;
    pism_event_model ev (.i_clk(clk), .i_rst_n(rst_n), .i_set(set),
        .i_clr(clr), .o_flags(flg));
    pism_summary_mask dut (.i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd),
        .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
        .i_global_irq_enable(gen), .i_thermal_shutdown_flag(flg[34]),
        .i_digital_supply_low_flag(flg[33]),
        .i_power_supply_low_flag(flg[32]),
        .i_port_start_timeout_flag(flg[31:28]),
        .i_port_overload_cut_flag(flg[27:24]),
        .i_port_current_limit_flag(flg[23:20]),
        .i_port_class_cycle_flag(flg[19:16]),
        .i_port_detect_cycle_flag(flg[15:12]),
        .i_port_disconnect_flag(flg[11:8]),
        .i_port_power_good_change_flag(flg[7:4]),
        .i_port_power_enable_change_flag(flg[3:0]),
        .o_event_summary_status(summ), .o_supply_uv_shutoff_en(shut),
        .o_int_n(int_n));
    // ==========================================
    // clock, access tasks and verdict
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task step;
        @(posedge clk) #1;
    endtask
    // drivers end with an idle edge so a strobe never toggles twice at once
    task reg_wr(input logic [7:0] c, input logic [7:0] d);
        cmd = c;
        wdata = d;
        wr = 1'b1;
        step();
        wr = 1'b0;
        step();
    endtask
    task reg_rd(input logic [7:0] c, input logic [7:0] e);
        cmd = c;
        rd = 1'b1;
        step();
        rd = 1'b0;
        `CHK(rdata, e)
        step();
    endtask
    task pulse(input logic [34:0] v);
        set = v;
        step();
        set = '0;
        step();
    endtask
    task clear;
        clr = 1'b1;
        step();
        clr = 1'b0;
        step();
    endtask
    task conclude;
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        #50000 n_errors++;
        conclude();
    end
    // ==========================================
    // test sequence
    initial
    begin
        set = '0;
        clr = 1'b0;
        cmd = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
        gen = 1'b1;
        exp_bit = 8'h00;
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        reg_rd(8'h01, `PISM_MASK_RESET);
        `CHK(shut, 1'b1)
        reg_rd(8'h00, 8'h80);
        `CHK(int_n, 1'b0)
        gen = 1'b0;
        step();
        `CHK(int_n, 1'b1)
        gen = 1'b1;
        clear();
        `CHK(summ, 8'h00)
        `CHK(int_n, 1'b1)
        // events cleared before unmasking all: no stale interrupt
        reg_wr(8'h01, 8'hFF);
        `CHK(int_n, 1'b1)
        reg_wr(8'h00, 8'h00);
        reg_rd(8'h01, 8'hFF);
        reg_rd(8'h00, 8'h00);
        reg_rd(8'h05, 8'h00);
        // mask read and write in one cycle: the read sees the old value
        cmd = 8'h01;
        wdata = 8'h5A;
        wr = 1'b1;
        rd = 1'b1;
        step();
        wr = 1'b0;
        rd = 1'b0;
        `CHK(rdata, 8'hFF)
        step();
        reg_rd(8'h01, 8'h5A);
        reg_wr(8'h01, 8'h00);
        `CHK(shut, 1'b0)
        // each flag alone: summary bit, mask gating, clear
        for (int k = 0; k < 35; k++)
        begin
            exp_bit = 8'h01 << (k / 4 - (k > 23));
            pulse(35'h1 << k);
            `CHK(summ, exp_bit)
            reg_rd(8'h00, exp_bit);
            `CHK(int_n, 1'b1)
            reg_wr(8'h01, exp_bit);
            `CHK(int_n, 1'b0)
            `CHK(summ, exp_bit)
            clear();
            `CHK(summ, 8'h00)
            `CHK(int_n, 1'b1)
            reg_wr(8'h01, 8'h00);
        end
        conclude();
    end
endmodule
`default_nettype wire
